// >>> bench/dma_bus_exception_control_properties.sv
/*
 Port assertions for the bus exception control block.
 Assumes one clock domain and the port names of the design's top module.
*/
`timescale 1ns/10ps
module dma_bus_exception_control_properties #(
   parameter int CHANNELS = 4,
   parameter int CH_WIDTH = 2
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [2:0] bus_exception_code_n_i,
   input wire logic cycle_done_o,
   input wire logic [2:0] cycle_outcome_o,
   input wire logic transfer_complete_strobe_o,
   input wire logic counter_update_o,
   input wire logic rerun_cycle_o,
   input wire logic bus_request_o,
   input wire logic bus_own_o,
   input wire logic start_allowed_o,
   input wire logic [CHANNELS-1:0] channel_error_o,
   input wire logic internal_reset_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   // Halt ends on the acknowledge, so only the three abort outcomes are counted as aborts.
   wire logic abort_done = cycle_done_o && (cycle_outcome_o == bus_exception_pkg::OUT_BUS_ERROR ||
      cycle_outcome_o == bus_exception_pkg::OUT_RETRY || cycle_outcome_o == bus_exception_pkg::OUT_RELINQUISH);

   a_strobe_normal_only: assert property (transfer_complete_strobe_o |->
      cycle_done_o && (cycle_outcome_o == bus_exception_pkg::OUT_NORMAL ||
      cycle_outcome_o == bus_exception_pkg::OUT_HALT)) else $error("strobe without normal end");
   a_abort_no_count: assert property (abort_done |->
      !transfer_complete_strobe_o && !counter_update_o) else $error("abort advanced counters");
   a_retry_keeps_bus: assert property (cycle_done_o && cycle_outcome_o == bus_exception_pkg::OUT_RETRY |->
      bus_own_o ##1 bus_own_o) else $error("retry dropped ownership");
   a_relinquish_drops_bus: assert property (cycle_done_o && cycle_outcome_o == bus_exception_pkg::OUT_RELINQUISH |->
      ##[0:2] !bus_own_o) else $error("relinquish kept ownership");
   a_exception_parks: assert property ((bus_exception_code_n_i != 3'h7 && bus_exception_code_n_i != 3'h0)[*6] |->
      !start_allowed_o) else $error("start allowed under exception");
   a_rerun_settled: assert property (rerun_cycle_o |->
      bus_exception_code_n_i == 3'h7 && $past(bus_exception_code_n_i, 4) == 3'h7) else $error("rerun too early");
   a_request_settled: assert property ($rose(bus_request_o) |->
      $past(bus_exception_code_n_i, 3) == 3'h7) else $error("request too early");
   a_error_logged: assert property (cycle_done_o && cycle_outcome_o == bus_exception_pkg::OUT_BUS_ERROR |->
      ##[0:1] channel_error_o != '0) else $error("bus error not logged");
   a_reset_clears: assert property (internal_reset_o |->
      $past(bus_exception_code_n_i, 4) == 3'h0 ##[0:2] channel_error_o == '0) else $error("reset sequence wrong");
endmodule

bind dma_bus_exception_control dma_bus_exception_control_properties #(.CHANNELS(CHANNELS), .CH_WIDTH(CH_WIDTH)) i_props (
   .clk_sys_i, .nrst_i, .bus_exception_code_n_i, .cycle_done_o, .cycle_outcome_o, .transfer_complete_strobe_o,
   .counter_update_o, .rerun_cycle_o, .bus_request_o, .bus_own_o, .start_allowed_o, .channel_error_o,
   .internal_reset_o);

// >>> bench/dma_bus_exception_control_tb_top.sv
/*
 Self-checking bench for the bus exception control block.
 Assumes the encoder model drives the pins; the bench plays the cycle sequencer.
*/
`timescale 1ns/10ps
module dma_bus_exception_control_tb_top;
   localparam int W_START = 0;
   localparam int W_RERUN = 1;
   localparam int W_REQ = 2;
   localparam int W_IRST = 3;
   localparam int W_DONE = 4;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic data_ack_i = 1'b0;
   logic cycle_active_i = 1'b0;
   logic [1:0] cycle_channel_i = 2'h0;
   logic dual_write_i = 1'b0;
   logic transfer_pending_i = 1'b1;
   logic operand_last_i = 1'b1;
   wire logic operand_lock_o;
   wire logic [2:0] code_n;
   wire logic granted;
   wire logic cycle_done_o;
   wire logic [2:0] cycle_outcome_o;
   wire logic transfer_complete_strobe_o;
   wire logic counter_update_o;
   wire logic rerun_cycle_o;
   wire logic bus_request_o;
   wire logic bus_own_o;
   wire logic start_allowed_o;
   wire logic [3:0] channel_error_o;
   wire logic internal_reset_o;
   wire logic [4:0] sigs = {cycle_done_o, internal_reset_o, bus_request_o, rerun_cycle_o, start_allowed_o};
   int err_total = 0;
   int checked = 0;
   int n_norm;

   initial forever #2.5 clk_sys_i = ~clk_sys_i;

   dma_bus_exception_control i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bus_exception_code_n_i(code_n),
      .data_ack_i(data_ack_i), .cycle_active_i(cycle_active_i), .cycle_channel_i(cycle_channel_i),
      .dual_write_i(dual_write_i), .transfer_pending_i(transfer_pending_i), .bus_granted_i(granted),
      .operand_last_i(operand_last_i), .cycle_done_o(cycle_done_o), .cycle_outcome_o(cycle_outcome_o),
      .transfer_complete_strobe_o(transfer_complete_strobe_o), .counter_update_o(counter_update_o),
      .rerun_cycle_o(rerun_cycle_o), .bus_request_o(bus_request_o), .bus_own_o(bus_own_o),
      .start_allowed_o(start_allowed_o), .operand_lock_o(operand_lock_o), .channel_error_o(channel_error_o),
      .internal_reset_o(internal_reset_o));
   exception_encoder_model i_far (.clk_sys_i(clk_sys_i), .bus_request_i(bus_request_o), .bus_own_i(bus_own_o),
      .bus_exception_code_n_o(code_n), .bus_granted_o(granted));

   task automatic check(input logic ok, input string what);
      checked++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask
   // Waits at falling edges, so every flag is read a half period after it settled.
   task automatic wait_sig(input int which, output int n);
      n = 0;
      while (sigs[which] !== 1'b1 && n < 100) begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n >= 100) check(1'b0, "wait timed out");
   endtask
   task automatic run_cycle(input logic [2:0] code, output int n);
      // One idle clock keeps the sequencer from dropping and raising its request in one step.
      @(negedge clk_sys_i);
      wait_sig(W_START, n);
      cycle_active_i = 1'b1;
      data_ack_i = 1'b1;
      i_far.present(code);
      wait_sig(W_DONE, n);
      n += 2;
      cycle_active_i = 1'b0;
      data_ack_i = 1'b0;
   endtask
   task automatic sc_glitch();
      int n;
      wait_sig(W_START, n);
      cycle_active_i = 1'b1;
      data_ack_i = 1'b1;
      i_far.code = 3'h3;
      @(negedge clk_sys_i);
      i_far.code = 3'h0;
      wait_sig(W_DONE, n);
      check(cycle_outcome_o === bus_exception_pkg::OUT_NORMAL, "one-clock code acted on");
      cycle_active_i = 1'b0;
      data_ack_i = 1'b0;
      run_cycle(3'h0, n_norm);
      check(transfer_complete_strobe_o === 1'b1 && counter_update_o === 1'b1, "normal end not counted");
   endtask
   task automatic sc_abort();
      int n;
      int rec[2];
      logic [2:0] code;
      for (int i = 0; i < 4; i++) begin
         code = (i == 3) ? 3'h2 : 3'(i + 2);
         dual_write_i = (i == 3);
         cycle_channel_i = 2'(i);
         operand_last_i = (i != 3);
         run_cycle(code, n);
         check(n == n_norm + 2, "abort latency");
         check(operand_lock_o === (i > 0), "operand lock wrong");
         check(cycle_outcome_o === 3'(i == 3 ? 1 : i + 1), "abort outcome");
         check(transfer_complete_strobe_o === 1'b0 && counter_update_o === 1'b0, "abort counted");
         if (code == 3'h3) check(bus_own_o === 1'b1, "retry dropped bus");
         repeat (2) @(negedge clk_sys_i);
         check(start_allowed_o === 1'b0, "start while parked");
         i_far.present(3'h0);
         if (code == 3'h2) begin
            wait_sig(W_START, n);
            rec[i / 3] = n + 2;
            check(channel_error_o[i] === 1'b1, "error not logged");
         end else begin
            wait_sig(W_RERUN, n);
            check(rerun_cycle_o === 1'b1 && n >= 4, "no rerun");
         end
      end
      dual_write_i = 1'b0;
      operand_last_i = 1'b1;
      check(rec[0] >= 25 && rec[1] - rec[0] == 4, "recovery length");
   endtask
   task automatic sc_halt();
      int n;
      i_far.grant_delay = 4;
      run_cycle(3'h1, n);
      check(n === n_norm + 2, "halt latency");
      check(cycle_outcome_o === bus_exception_pkg::OUT_HALT, "halt outcome");
      repeat (3) @(negedge clk_sys_i);
      check(bus_own_o === 1'b0 && bus_request_o === 1'b0, "halt kept bus");
      i_far.present(3'h0);
      wait_sig(W_REQ, n);
      check(n >= 4, "request too soon");
      i_far.grant_delay = 1;
   endtask
   task automatic sc_reserved();
      int n;
      for (int c = 5; c < 7; c++) begin
         @(negedge clk_sys_i);
         wait_sig(W_START, n);
         cycle_active_i = 1'b1;
         i_far.present(3'(c));
         data_ack_i = 1'b1;
         repeat (2) @(negedge clk_sys_i);
         repeat (10) begin
            @(negedge clk_sys_i);
            check(cycle_done_o !== 1'b1 && start_allowed_o === 1'b0, "reserved code not stretching");
         end
         i_far.present(3'h0);
         wait_sig(W_DONE, n);
         check(cycle_outcome_o === bus_exception_pkg::OUT_NORMAL, "reserved acted on");
         cycle_active_i = 1'b0;
         data_ack_i = 1'b0;
      end
   endtask
   task automatic sc_reset();
      int n;
      i_far.present(3'h7);
      wait_sig(W_IRST, n);
      check(n + 2 <= 5, "reset late");
      repeat (3) @(negedge clk_sys_i);
      check(channel_error_o === 4'h0 && bus_own_o === 1'b0, "reset left state");
      i_far.present(3'h0);
      wait_sig(W_START, n);
   endtask
   task automatic complete_run();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (6) @(negedge clk_sys_i);
      nrst_i = 1'b1;
      sc_glitch();
      sc_abort();
      sc_halt();
      sc_reserved();
      sc_reset();
      complete_run();
   end
   // The scenarios need well under 2000 clocks; this cuts a hang at 20000.
   initial begin
      #100000;
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      complete_run();
   end
endmodule

// >>> bench/exception_encoder_model.sv
/*
 Model of the system exception encoder and bus arbiter.
 Assumes the bench calls present from falling-edge time steps.
*/
`timescale 1ns/10ps
module exception_encoder_model #(
   parameter int GRANT_DELAY = 1
) (
   input wire logic clk_sys_i,
   input wire logic bus_request_i,
   input wire logic bus_own_i,
   output logic [2:0] bus_exception_code_n_o,
   output logic bus_granted_o
);
   logic [2:0] code = 3'h0;
   int grant_delay = GRANT_DELAY;
   int cnt = 0;
   initial bus_granted_o = 1'b0;
   // Pins are active low with line zero least significant, so normal is all high.
   assign bus_exception_code_n_o = ~code;
   // Every code stays at least two clocks, which also puts a halt ahead of the next cycle start.
   task automatic present(input logic [2:0] value);
      code = value;
      repeat (2) @(negedge clk_sys_i);
   endtask
   // The grant waits a settable delay and stays while the device owns the bus.
   always @(negedge clk_sys_i) begin
      cnt <= bus_request_i ? cnt + 1 : 0;
      bus_granted_o <= (bus_request_i && cnt >= grant_delay) || (bus_granted_o && bus_own_i);
   end
endmodule

// >>> src/bus_exception_pkg.sv
/*
 Package for the bus exception control block: exception codes, outcome and
 state encodings, and cycle counts. Assumes a single 200 MHz system clock.
*/
package bus_exception_pkg;

   // ----------------------------------------------------------------
   // Exception codes
   // ----------------------------------------------------------------
   localparam logic [2:0] CODE_NORMAL = 3'h0;
   localparam logic [2:0] CODE_HALT = 3'h1;
   localparam logic [2:0] CODE_BUS_ERROR = 3'h2;
   localparam logic [2:0] CODE_RETRY = 3'h3;
   localparam logic [2:0] CODE_RELINQUISH = 3'h4;
   localparam logic [2:0] CODE_RESERVED_A = 3'h5;
   localparam logic [2:0] CODE_RESERVED_B = 3'h6;
   localparam logic [2:0] CODE_RESET = 3'h7;

   // ----------------------------------------------------------------
   // Cycle counts
   // ----------------------------------------------------------------
   localparam int REARB_WAIT_CYCLES = 3;
   localparam int RECOVERY_CYCLES = 25;
   localparam int RECOVERY_DUAL_WRITE_CYCLES = 29;
   localparam int RESERVED_HOLDOFF_CYCLES = 2;
   localparam int COUNT_WIDTH = 5;

   // ----------------------------------------------------------------
   // Cycle termination outcome reported with cycle_done_o
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OUT_NORMAL = 3'b000,
      OUT_BUS_ERROR = 3'b001,
      OUT_RETRY = 3'b010,
      OUT_RELINQUISH = 3'b011,
      OUT_HALT = 3'b100
   } outcome_type;

   // ----------------------------------------------------------------
   // Controller states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CYCLE = 3'b001,
      ST_HOLD = 3'b010,
      ST_WAIT = 3'b011,
      ST_RECOVER = 3'b100,
      ST_REARB = 3'b101
   } state_type;

endpackage

// >>> src/dma_bus_exception_control.sv
/*
 Bus exception control for a multi-channel DMA bus master: turns the filtered
 exception code into cycle terminations, bus release, retry and recovery.
 Assumes a bus-cycle sequencer that raises cycle_active_i for each cycle and
 samples the outputs here, and an arbiter that answers bus_request_o.
*/
// Notes on behaviour
// - Three code lines form value 0..7, line zero least significant, all high means zero.
// - Code inputs captured each rising edge, then synchronised one edge later.
// - Two latest synchronised codes must match before the code is acted upon.
// - Error, retry or relinquish ends the cycle after sync, debounce and controller clock.
// - Error, retry or relinquish arriving with acknowledge overrides that acknowledge.
// - Any non-zero code parks the device idle or waiting after the cycle ends.
// - Code zero: each cycle ends on data transfer acknowledge.
// - Halt: finish on acknowledge, release bus, idle, then re-arbitrate and resume.
// - Halt with acknowledge together ends the cycle two clocks later.
// - After halt clears, wait three clocks before raising bus request.
// - Bus error aborts cycle and channel, logging error in that channel.
// - After bus error clears, recover 25 clocks, or 29 for dual-address write.
// - Bus error: no transfer-complete strobe, address and count counters unchanged.
// - Retry: end cycle, wait holding grant, after clear wait three clocks, rerun.
// - Retry: no strobe, counters and data holding register untouched.
// - Relinquish: end cycle, release bus, after clear wait three, re-arbitrate, rerun.
// - Relinquish: no strobe, counters and data holding register untouched.
// - Retried operand transfer completes before any higher-priority channel.
// - Codes 5 and 6 stretch the cycle and block requests until sync plus debounce.
// - Code 7 starts internal reset and idle after sync plus debounce.
`timescale 1ns/10ps
module dma_bus_exception_control #(
   parameter int CHANNELS = 4,
   parameter int CH_WIDTH = 2
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [2:0] bus_exception_code_n_i,
   input wire logic data_ack_i,
   input wire logic cycle_active_i,
   input wire logic [CH_WIDTH-1:0] cycle_channel_i,
   input wire logic dual_write_i,
   input wire logic transfer_pending_i,
   input wire logic bus_granted_i,
   input wire logic operand_last_i,
   output logic cycle_done_o,
   output logic [2:0] cycle_outcome_o,
   output logic transfer_complete_strobe_o,
   output logic counter_update_o,
   output logic rerun_cycle_o,
   output logic bus_request_o,
   output logic bus_own_o,
   output logic start_allowed_o,
   output logic operand_lock_o,
   output logic [CHANNELS-1:0] channel_error_o,
   output logic internal_reset_o
);

   if (CHANNELS < 1 || CHANNELS > (1 << CH_WIDTH)) begin : g_channels_fit
      $error("CHANNELS does not fit CH_WIDTH");
   end

   // ----------------------------------------------------------------
   // Code filter
   // ----------------------------------------------------------------
   logic [2:0] code;
   logic code_valid;

   exception_code_filter #(
      .WIDTH(3)
   ) u_filter (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .bus_exception_code_n_i(bus_exception_code_n_i),
      .code_o(code),
      .code_valid_o(code_valid)
   );

   // ----------------------------------------------------------------
   // Code decode
   // ----------------------------------------------------------------
   wire logic is_normal = (code == bus_exception_pkg::CODE_NORMAL);
   wire logic is_halt = (code == bus_exception_pkg::CODE_HALT);
   wire logic is_error = (code == bus_exception_pkg::CODE_BUS_ERROR);
   wire logic is_retry = (code == bus_exception_pkg::CODE_RETRY);
   wire logic is_relinquish = (code == bus_exception_pkg::CODE_RELINQUISH);
   wire logic is_reserved = (code == bus_exception_pkg::CODE_RESERVED_A) ||
      (code == bus_exception_pkg::CODE_RESERVED_B);
   wire logic is_reset = (code == bus_exception_pkg::CODE_RESET);
   wire logic is_abort = is_error || is_retry || is_relinquish;

   bus_exception_pkg::state_type state;
   bus_exception_pkg::state_type next_state;
   bus_exception_pkg::outcome_type held_outcome;
   bus_exception_pkg::outcome_type next_held_outcome;
   logic [bus_exception_pkg::COUNT_WIDTH-1:0] count;
   logic [bus_exception_pkg::COUNT_WIDTH-1:0] next_count;
   logic [1:0] reserved_hold;
   logic [1:0] next_reserved_hold;
   logic ack_seen;
   logic pending_rerun;
   logic next_pending_rerun;
   logic exc_armed;

   // Termination decision for an active cycle.
   // The acknowledge crosses a three-stage delay, one clock less than the code's sync and
   // debounce path, and an exception termination spends one more controller clock in exc_armed,
   // so aborts and halt plus acknowledge end two clocks after a plain acknowledge would.
   wire logic arm_now = (state == bus_exception_pkg::ST_CYCLE) && code_valid &&
      (is_abort || (is_halt && ack_seen));
   wire logic end_abort = arm_now && exc_armed && is_abort;
   wire logic end_ack = (state == bus_exception_pkg::ST_CYCLE) && code_valid && ack_seen &&
      (is_normal || (is_halt && exc_armed));
   wire logic end_reset = code_valid && is_reset;
   wire logic [bus_exception_pkg::COUNT_WIDTH-1:0] recovery_len = dual_write_i ?
      bus_exception_pkg::COUNT_WIDTH'(bus_exception_pkg::RECOVERY_DUAL_WRITE_CYCLES - 1) :
      bus_exception_pkg::COUNT_WIDTH'(bus_exception_pkg::RECOVERY_CYCLES - 1);
   wire logic [bus_exception_pkg::COUNT_WIDTH-1:0] rearb_len =
      bus_exception_pkg::COUNT_WIDTH'(bus_exception_pkg::REARB_WAIT_CYCLES - 1);
   wire logic code_clear = code_valid && is_normal;
   wire logic halted_or_parked = code_valid && !is_normal && !is_reserved;

   // ----------------------------------------------------------------
   // Acknowledge delay, one clock shorter than the code path
   // ----------------------------------------------------------------
   logic [2:0] ack_pipe;

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ack_pipe <= 3'h0;
      end else if (end_abort || end_ack || end_reset) begin
         // A finished cycle must not hand its acknowledge on to the next one.
         ack_pipe <= 3'h0;
      end else begin
         ack_pipe <= {ack_pipe[1:0], data_ack_i && cycle_active_i};
      end
   end

   // ----------------------------------------------------------------
   // Exception termination arming
   // ----------------------------------------------------------------
   // The controller needs one clock to switch from a normal to an exception
   // termination; a code that changes meanwhile drops the arming again.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         exc_armed <= 1'b0;
      end else begin
         exc_armed <= arm_now && !end_abort && !end_ack && !end_reset;
      end
   end

   assign ack_seen = ack_pipe[2];

   // ----------------------------------------------------------------
   // State sequencing
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_count = (count != '0) ? count - 1'b1 : count;
      next_held_outcome = held_outcome;
      next_pending_rerun = pending_rerun;
      next_reserved_hold = (reserved_hold != 2'h0) ? reserved_hold - 2'h1 : reserved_hold;
      if (code_valid && is_reserved) begin
         next_reserved_hold = 2'(bus_exception_pkg::RESERVED_HOLDOFF_CYCLES);
      end
      case (state)
         bus_exception_pkg::ST_IDLE: begin
            if (cycle_active_i && start_allowed_o) begin
               next_state = bus_exception_pkg::ST_CYCLE;
            end
         end
         bus_exception_pkg::ST_CYCLE: begin
            if (end_abort) begin
               next_state = bus_exception_pkg::ST_HOLD;
               next_pending_rerun = !is_error;
               if (is_error) begin
                  next_held_outcome = bus_exception_pkg::OUT_BUS_ERROR;
               end else if (is_retry) begin
                  next_held_outcome = bus_exception_pkg::OUT_RETRY;
               end else begin
                  next_held_outcome = bus_exception_pkg::OUT_RELINQUISH;
               end
            end else if (end_ack && is_halt) begin
               next_state = bus_exception_pkg::ST_HOLD;
               next_held_outcome = bus_exception_pkg::OUT_HALT;
            end else if (end_ack) begin
               next_state = bus_exception_pkg::ST_IDLE;
            end
            // Reserved codes leave the cycle running whatever the acknowledge does.
         end
         bus_exception_pkg::ST_HOLD: begin
            if (code_clear) begin
               if (held_outcome == bus_exception_pkg::OUT_BUS_ERROR) begin
                  next_state = bus_exception_pkg::ST_RECOVER;
                  next_count = recovery_len;
               end else begin
                  next_state = bus_exception_pkg::ST_WAIT;
                  next_count = rearb_len;
               end
            end
         end
         bus_exception_pkg::ST_WAIT: begin
            if (!code_clear) begin
               next_state = bus_exception_pkg::ST_HOLD;
            end else if (count == '0) begin
               next_state = (held_outcome == bus_exception_pkg::OUT_RETRY) ?
                  bus_exception_pkg::ST_IDLE : bus_exception_pkg::ST_REARB;
            end
         end
         bus_exception_pkg::ST_RECOVER: begin
            if (count == '0) begin
               next_state = bus_exception_pkg::ST_IDLE;
            end
         end
         bus_exception_pkg::ST_REARB: begin
            if (bus_granted_i || !(transfer_pending_i || pending_rerun)) begin
               next_state = bus_exception_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = bus_exception_pkg::ST_IDLE;
         end
      endcase
      if (state == bus_exception_pkg::ST_CYCLE && end_ack && pending_rerun) begin
         next_pending_rerun = 1'b0;
      end
      if (end_reset) begin
         next_state = bus_exception_pkg::ST_IDLE;
         next_pending_rerun = 1'b0;
         next_count = '0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= bus_exception_pkg::ST_IDLE;
         held_outcome <= bus_exception_pkg::OUT_NORMAL;
         count <= '0;
         pending_rerun <= 1'b0;
         reserved_hold <= 2'h0;
      end else begin
         state <= next_state;
         held_outcome <= next_held_outcome;
         count <= next_count;
         pending_rerun <= next_pending_rerun;
         reserved_hold <= next_reserved_hold;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   wire logic done_now = end_abort || end_ack;
   wire logic normal_done = end_ack && !end_abort;
   wire logic owns_next = (state == bus_exception_pkg::ST_HOLD || state == bus_exception_pkg::ST_WAIT) ?
      (held_outcome == bus_exception_pkg::OUT_RETRY) :
      (state == bus_exception_pkg::ST_CYCLE || state == bus_exception_pkg::ST_RECOVER ||
       (state == bus_exception_pkg::ST_IDLE && bus_own_o && transfer_pending_i));
   wire logic request_next = (state == bus_exception_pkg::ST_REARB) && !bus_granted_i &&
      (transfer_pending_i || pending_rerun);
   wire logic allow_next = !halted_or_parked && !(code_valid && is_reserved) &&
      (next_reserved_hold == 2'h0) && (next_state == bus_exception_pkg::ST_IDLE ||
      next_state == bus_exception_pkg::ST_CYCLE);

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cycle_done_o <= 1'b0;
         cycle_outcome_o <= 3'h0;
         transfer_complete_strobe_o <= 1'b0;
         counter_update_o <= 1'b0;
         rerun_cycle_o <= 1'b0;
         bus_request_o <= 1'b0;
         bus_own_o <= 1'b0;
         start_allowed_o <= 1'b0;
         operand_lock_o <= 1'b0;
         channel_error_o <= '0;
         internal_reset_o <= 1'b0;
      end else begin
         cycle_done_o <= done_now && !end_reset;
         cycle_outcome_o <= next_held_outcome;
         if (normal_done && !is_halt) begin
            cycle_outcome_o <= bus_exception_pkg::OUT_NORMAL;
         end
         transfer_complete_strobe_o <= normal_done && !end_reset;
         counter_update_o <= normal_done && !end_reset;
         rerun_cycle_o <= pending_rerun && (next_state == bus_exception_pkg::ST_IDLE) && !end_reset &&
            (state == bus_exception_pkg::ST_WAIT || state == bus_exception_pkg::ST_REARB);
         bus_request_o <= request_next && !end_reset;
         bus_own_o <= owns_next && !end_reset;
         start_allowed_o <= allow_next && !end_reset;
         // The retried operand keeps priority while a rerun is owed.
         operand_lock_o <= next_pending_rerun || (pending_rerun && !operand_last_i);
         if (end_abort && is_error) begin
            channel_error_o[cycle_channel_i] <= 1'b1;
         end
         if (end_reset) begin
            channel_error_o <= '0;
         end
         internal_reset_o <= end_reset;
      end
   end

endmodule

// >>> src/exception_code_filter.sv
/*
 Two-stage synchroniser followed by a debounce stage for the three-bit
 exception code. Assumes the code is active low on the pins, one clock.
*/
`timescale 1ns/10ps
module exception_code_filter #(
   parameter int WIDTH = 3
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [WIDTH-1:0] bus_exception_code_n_i,
   output logic [WIDTH-1:0] code_o,
   output logic code_valid_o
);

   logic [WIDTH-1:0] capture;
   logic [WIDTH-1:0] sync_now;
   logic [WIDTH-1:0] sync_prev;
   wire logic [WIDTH-1:0] pin_value = ~bus_exception_code_n_i;
   wire logic agree = (sync_now == sync_prev);

   // ----------------------------------------------------------------
   // Capture, synchronise, debounce
   // ----------------------------------------------------------------
   // All lines high on the pins reads as code zero after inversion.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         capture <= '0;
         sync_now <= '0;
         sync_prev <= '0;
         code_o <= '0;
         code_valid_o <= 1'b0;
      end else begin
         capture <= pin_value;
         sync_now <= capture;
         sync_prev <= sync_now;
         code_valid_o <= agree;
         // A transitional code from a priority encoder is never accepted.
         if (agree) begin
            code_o <= sync_now;
         end
      end
   end

endmodule
